/* File: verilog/display_link_pkg.sv */
// shared constants and types for the display host link
package display_link_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int SYS_CLK_MHZ = 50;
   localparam int SYS_PERIOD_NS = 20;
   localparam int SCLK_CYCLE_MIN_NS = 250;
   // half serial clock period, rounded up to whole system cycles
   localparam int SCLK_HALF =
      (SCLK_CYCLE_MIN_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int PANEL_SETTLE_MS = 100;
   // milliseconds to microseconds, then cycles per microsecond
   localparam int PANEL_SETTLE_CYCLES = PANEL_SETTLE_MS * 1000
      * SYS_CLK_MHZ;

   // ****************************************
   // link layout
   // ****************************************
   localparam int BUS_W = 8;
   localparam int SCLK_BIT = 0;
   localparam int SERIAL_IN_BIT = 1;
   localparam int I2C_OUT_BIT = 2;
   localparam logic [5:0] I2C_ADDR_HI = 6'h1e;
   localparam logic [7:0] HOST_BUS_OE = 8'hfb;
   localparam logic [7:0] BUS_ALL = 8'hff;

   // ****************************************
   // host register map
   // ****************************************
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_TXDATA = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam int CTRL_RESET_BIT = 0;
   localparam int CTRL_LOGIC_BIT = 1;
   localparam int CTRL_PANEL_BIT = 2;
   localparam logic CTRL_RESET_INIT = 1'b1;
   localparam int TX_DC_BIT = 8;
   localparam int ST_EMPTY_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_SETTLED_BIT = 2;
   localparam int ST_FULL_BIT = 3;
   localparam int FIFO_W = 9;
   localparam int FIFO_D = 4;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      M_SPI = 2'b00,
      M_I2C = 2'b01,
      M_P68 = 2'b10,
      M_P80 = 2'b11
   } mode_t;

   typedef enum logic [2:0] {
      I_IDLE = 3'b000,
      I_ADDR = 3'b001,
      I_CTRL = 3'b010,
      I_DATA = 3'b011
   } i2c_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SHIFT = 2'b01,
      H_END = 2'b10
   } spi_t;

   typedef struct packed {
      logic csN;
      logic dc;
      logic rw;
      logic enRd;
      logic bsLo;
      logic bsHi;
      logic [7:0] bus;
      logic rstN;
   } pins_t;

   function automatic mode_t busMode(input logic lo, input logic hi);
      busMode = mode_t'({hi, lo});
   endfunction

endpackage

/* File: verilog/display_link_if.sv */
// wires between the host end and the display controller end
`timescale 1ns/10ps
interface display_link_if;
   logic csN;
   logic dcSel;
   logic hwResetN;
   logic rwSel;
   logic enRd;
   logic [7:0] hostBusOut;
   logic [7:0] hostBusOe;
   logic [7:0] devBusOut;
   logic [7:0] devBusOe;
   logic [7:0] busLevel;

   // undriven lines float high; bit 1 also carries the joined data out line
   // bits 2 and 1 joined outside the controller for i2c [RL14]
   for (genvar i = 0; i < 8; i++) begin : g_bus
      logic hostLvl;
      logic devLvl;
      logic joinLvl;
      assign hostLvl = hostBusOe[i] ? hostBusOut[i] : 1'b1;
      assign devLvl = devBusOe[i] ? devBusOut[i] : 1'b1;
      if (i == 1) begin : g_join
         assign joinLvl = devBusOe[2] ? devBusOut[2] : 1'b1;
      end else begin : g_nojoin
         assign joinLvl = 1'b1;
      end
      assign busLevel[i] = hostLvl & devLvl & joinLvl;
   end

   modport host(
      output csN, dcSel, hwResetN, rwSel, enRd, hostBusOut, hostBusOe,
      input busLevel
   );
   modport device(
      input csN, dcSel, hwResetN, rwSel, enRd, busLevel,
      output devBusOut, devBusOe
   );
endinterface

/* File: verilog/byte_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
   parameter int W = 9,
   parameter int D = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wrValid,
   output logic wrReady,
   input wire logic [W-1:0] wrData,
   output logic rdValid,
   input wire logic rdReady,
   output logic [W-1:0] rdData
);
   localparam int PW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] count;
   } fifo_t;

   fifo_t r;
   fifo_t next_r;
   logic push;
   logic pop;

   assign wrReady = r.count != CW'(D);
   assign rdValid = r.count != '0;
   assign rdData = r.mem[r.rp];
   assign push = wrValid & wrReady;
   assign pop = rdValid & rdReady;

   always_comb begin
      next_r = r;
      if (push) begin
         next_r.mem[r.wp] = wrData;
         next_r.wp = (r.wp == PW'(D - 1)) ? '0 : PW'(r.wp + 1'b1);
      end
      if (pop) begin
         next_r.rp = (r.rp == PW'(D - 1)) ? '0 : PW'(r.rp + 1'b1);
      end
      if (push && !pop) begin
         next_r.count = CW'(r.count + 1'b1);
      end else if (pop && !push) begin
         next_r.count = CW'(r.count - 1'b1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule

/* File: verilog/display_device_end.sv */
// display controller end of the host link: serial, i2c and parallel ports
`timescale 1ns/10ps
// Functional notes
// RL1 - chip select low gates all bus traffic
// RL2 - reset pin low initialises the controller
// RL3 - host keeps reset high in normal use
// RL4 - serial: select high data, low command
// RL5 - i2c: select pin is address lsb
// RL6 - i2c address 0111100 or 0111101
// RL7 - 68 style: read/write pin sets direction
// RL8 - 68 style: enable high starts cycle
// RL9 - 80 style: read strobe low starts read
// RL10 - 80 style: write strobe low starts write
// RL11 - host ties strobes low in serial/i2c
// RL12 - eight bit bidirectional parallel bus
// RL13 - serial: bit1 data in, bit0 clock
// RL14 - i2c: bits 2,1 joined, bit0 clock
// RL15 - unused bus pins grounded, bit2 open
// RL16 - host power-up order with 100ms wait
// RL17 - host power-down order with 100ms wait
// RL18 - unused chip select tied to ground
// RL19 - serial msb first, rising edge, dc last
module display_device_end
   import display_link_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   display_link_if.device link,
   input wire logic busSelLo,
   input wire logic busSelHi,
   input wire logic [7:0] readByte,
   output logic [7:0] rxData,
   output logic rxDc,
   output logic rxValid,
   output logic initActive
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      pins_t s1;
      pins_t s2;
      pins_t prev;
      i2c_t i2c;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic ctrlDc;
      logic [7:0] busOut;
      logic [7:0] busOe;
      logic [7:0] rxData;
      logic rxDc;
      logic rxValid;
      logic initActive;
   } dev_t;

   // reset pin taken as low until the chain fills, so no false release
   localparam dev_t DEV_RESET = '{
      s1: '{rstN: 1'b0, default: '1},
      s2: '{rstN: 1'b0, default: '1},
      prev: '1,
      i2c: I_IDLE,
      initActive: 1'b1,
      default: '0
   };

   dev_t r;
   dev_t next_r;
   pins_t pinNow;
   mode_t mode;
   logic sclRise;
   logic sclFall;
   logic sclHigh;
   logic selected;

   // every pin, straps included, goes through two flops first
   assign pinNow = '{
      csN: link.csN,
      dc: link.dcSel,
      rw: link.rwSel,
      enRd: link.enRd,
      bsLo: busSelLo,
      bsHi: busSelHi,
      bus: link.busLevel,
      rstN: link.hwResetN
   };

   assign mode = busMode(r.s2.bsLo, r.s2.bsHi);
   assign sclRise = r.s2.bus[SCLK_BIT] & ~r.prev.bus[SCLK_BIT];
   assign sclFall = ~r.s2.bus[SCLK_BIT] & r.prev.bus[SCLK_BIT];
   assign sclHigh = r.s2.bus[SCLK_BIT] & r.prev.bus[SCLK_BIT];
   assign selected = ~r.s2.csN;

   assign link.devBusOut = r.busOut;
   assign link.devBusOe = r.busOe;
   assign rxData = r.rxData;
   assign rxDc = r.rxDc;
   assign rxValid = r.rxValid;
   assign initActive = r.initActive;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic ack;
      ack = 1'b0;
      next_r = r;
      next_r.s1 = pinNow;
      next_r.s2 = r.s1;
      next_r.prev = r.s2;
      next_r.rxValid = 1'b0;

      if (!r.s2.rstN) begin
         // controller held in its initial state, rxData, rxDc and busOut kept [RL2]
         next_r.i2c = I_IDLE;
         next_r.cnt = '0;
         next_r.shift = '0;
         next_r.ctrlDc = 1'b0;
         next_r.busOe = '0;
         next_r.initActive = 1'b1;
      end else if (!selected) begin
         // deselected: bus released, partial bytes dropped [RL1]
         next_r.initActive = 1'b0;
         next_r.i2c = I_IDLE;
         next_r.cnt = '0;
         next_r.busOe = '0;
      end else begin
         next_r.initActive = 1'b0;
         case (mode)
            M_SPI: begin
               next_r.busOe = '0;
               if (sclRise) begin
                  // msb first on the rising clock [RL13] [RL19]
                  next_r.shift = {r.shift[6:0], r.s2.bus[SERIAL_IN_BIT]};
                  if (r.cnt == 4'h7) begin
                     next_r.cnt = '0;
                     next_r.rxData = {r.shift[6:0], r.s2.bus[SERIAL_IN_BIT]};
                     next_r.rxDc = r.s2.dc; // [RL4] [RL19]
                     next_r.rxValid = 1'b1;
                  end else begin
                     next_r.cnt = r.cnt + 4'h1;
                  end
               end
            end
            M_P80: begin
               // read strobe low drives the whole bus [RL9] [RL12]
               next_r.busOut = readByte;
               next_r.busOe = r.s2.enRd ? '0 : BUS_ALL;
               if (!r.s2.rw && r.prev.rw) begin
                  next_r.cnt = 4'h1; // [RL10]
               end else if (r.s2.rw && !r.prev.rw && r.cnt[0]) begin
                  // data latched at the trailing strobe edge
                  next_r.cnt = '0;
                  next_r.rxData = r.prev.bus;
                  next_r.rxDc = r.prev.dc;
                  next_r.rxValid = 1'b1;
               end
            end
            M_P68: begin
               next_r.busOut = readByte;
               next_r.busOe = (r.s2.enRd && r.s2.rw) ? BUS_ALL : '0; // [RL7]
               if (r.s2.enRd && !r.prev.enRd) begin
                  next_r.cnt = {3'h0, ~r.s2.rw}; // [RL8]
               end else if (!r.s2.enRd && r.prev.enRd && r.cnt[0]) begin
                  next_r.cnt = '0;
                  next_r.rxData = r.prev.bus;
                  next_r.rxDc = r.prev.dc;
                  next_r.rxValid = 1'b1;
               end
            end
            M_I2C: begin
               next_r.busOut = '0;
               if (sclHigh && r.prev.bus[SERIAL_IN_BIT] && !r.s2.bus[SERIAL_IN_BIT]) begin
                  next_r.i2c = I_ADDR;
                  next_r.cnt = '0;
                  next_r.busOe = '0;
               end else if (sclHigh && !r.prev.bus[SERIAL_IN_BIT]
                            && r.s2.bus[SERIAL_IN_BIT]) begin
                  next_r.i2c = I_IDLE;
                  next_r.busOe = '0;
               end else if (r.i2c != I_IDLE) begin
                  if (sclRise && r.cnt < 4'h8) begin
                     next_r.shift = {r.shift[6:0], r.s2.bus[SERIAL_IN_BIT]};
                     next_r.cnt = r.cnt + 4'h1;
                  end else if (sclRise) begin
                     next_r.cnt = 4'h9;
                  end else if (sclFall && r.cnt == 4'h8) begin
                     ack = 1'b1;
                     case (r.i2c)
                        I_ADDR: begin
                           // select pin doubles as address lsb [RL5] [RL6]
                           if (r.shift[7:1] == {I2C_ADDR_HI, r.s2.dc}
                               && !r.shift[0]) begin
                              next_r.i2c = I_CTRL;
                           end else begin
                              ack = 1'b0;
                              next_r.i2c = I_IDLE;
                           end
                        end
                        I_CTRL: begin
                           next_r.ctrlDc = r.shift[6];
                           next_r.i2c = I_DATA;
                        end
                        I_DATA: begin
                           next_r.rxData = r.shift;
                           next_r.rxDc = r.ctrlDc;
                           next_r.rxValid = 1'b1;
                        end
                        default: begin
                           ack = 1'b0;
                        end
                     endcase
                     // acknowledge pulls the joined data line low
                     next_r.busOe = {5'h00, ack, 2'h0};
                  end else if (sclFall && r.cnt == 4'h9) begin
                     next_r.busOe = '0;
                     next_r.cnt = '0;
                  end
               end
            end
            default: begin
               next_r.busOe = '0;
            end
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= DEV_RESET;
      end else begin
         r <= next_r;
      end
   end

endmodule

/* File: verilog/display_host_end.sv */
// host end: apb registers, tx fifo, 4-wire serial master, power sequencing
`timescale 1ns/10ps
module display_host_end
   import display_link_pkg::*;
#(
   parameter int SETTLE_CYCLES = PANEL_SETTLE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   display_link_if.host link,
   output logic logicSupplyEn,
   output logic panelSupplyEn
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic resetAssert;
      logic logicEn;
      logic panelEn;
      logic [22:0] timer;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      spi_t spi;
      logic [3:0] div;
      logic [2:0] bitIdx;
      logic [7:0] shift;
      logic sclk;
      logic serial_in;
      logic csN;
      logic dc;
   } host_t;

   localparam host_t HOST_RESET = '{
      resetAssert: CTRL_RESET_INIT,
      spi: H_IDLE,
      csN: 1'b1,
      default: '0
   };

   host_t r;
   host_t next_r;
   logic access;
   logic txWrite;
   logic fifoReady;
   logic fifoValid;
   logic [FIFO_W-1:0] fifoData;
   logic popReady;

   assign access = psel & penable & ~r.pready;
   assign txWrite = access & pwrite & (paddr == REG_TXDATA);
   assign popReady = (r.spi == H_IDLE) & ~r.resetAssert;

   // full fifo stalls the apb write until a byte leaves
   byte_fifo #(
      .W(FIFO_W),
      .D(FIFO_D)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .wrValid(txWrite),
      .wrReady(fifoReady),
      .wrData(pwdata[FIFO_W-1:0]),
      .rdValid(fifoValid),
      .rdReady(popReady),
      .rdData(fifoData)
   );

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign logicSupplyEn = r.logicEn;
   assign panelSupplyEn = r.panelEn;
   assign link.csN = r.csN;
   assign link.dcSel = r.dc;
   assign link.hwResetN = ~r.resetAssert; // [RL3]
   assign link.rwSel = 1'b0; // [RL11]
   assign link.enRd = 1'b0; // [RL11]
   assign link.hostBusOut = {5'h00, 1'b0, r.serial_in, r.sclk}; // [RL13]
   assign link.hostBusOe = HOST_BUS_OE; // [RL15]

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic wantPanel;
      logic wantLogic;
      wantPanel = 1'b0;
      wantLogic = 1'b0;
      next_r = r;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      if (r.timer != '0) begin
         next_r.timer = r.timer - 23'h1;
      end

      if (access) begin
         next_r.pready = 1'b1;
         next_r.prdata = '0;
         case (paddr)
            REG_CTRL: begin
               if (pwrite) begin
                  // panel only on if logic was up before the write; logic stays up
                  // while panel was on before the write or still discharging [RL16] [RL17]
                  wantPanel = pwdata[CTRL_PANEL_BIT] & r.logicEn;
                  wantLogic = pwdata[CTRL_LOGIC_BIT] | r.panelEn
                     | (r.timer != '0);
                  next_r.resetAssert = pwdata[CTRL_RESET_BIT];
                  next_r.logicEn = wantLogic;
                  next_r.panelEn = wantPanel;
                  if (wantPanel != r.panelEn) begin
                     next_r.timer = 23'(SETTLE_CYCLES);
                  end
               end else begin
                  next_r.prdata[CTRL_RESET_BIT] = r.resetAssert;
                  next_r.prdata[CTRL_LOGIC_BIT] = r.logicEn;
                  next_r.prdata[CTRL_PANEL_BIT] = r.panelEn;
               end
            end
            REG_TXDATA: begin
               next_r.pready = ~pwrite | fifoReady;
            end
            REG_STATUS: begin
               next_r.prdata[ST_EMPTY_BIT] = ~fifoValid;
               next_r.prdata[ST_BUSY_BIT] = fifoValid | (r.spi != H_IDLE);
               next_r.prdata[ST_SETTLED_BIT] = (r.timer == '0);
               next_r.prdata[ST_FULL_BIT] = ~fifoReady;
            end
            default: begin
               next_r.pslverr = 1'b1;
            end
         endcase
      end

      // serial master: data changes while clock is low, msb first
      case (r.spi)
         H_IDLE: begin
            if (fifoValid && popReady) begin
               next_r.spi = H_SHIFT;
               next_r.csN = 1'b0; // [RL1]
               next_r.dc = fifoData[TX_DC_BIT]; // [RL4]
               next_r.shift = fifoData[7:0];
               next_r.serial_in = fifoData[7]; // [RL19]
               next_r.sclk = 1'b0;
               next_r.bitIdx = '0;
               next_r.div = 4'(SCLK_HALF - 1);
            end
         end
         H_SHIFT: begin
            if (r.div != '0) begin
               next_r.div = r.div - 4'h1;
            end else begin
               next_r.div = 4'(SCLK_HALF - 1);
               if (!r.sclk) begin
                  next_r.sclk = 1'b1;
               end else begin
                  next_r.sclk = 1'b0;
                  if (r.bitIdx == 3'h7) begin
                     next_r.spi = H_END;
                  end else begin
                     next_r.bitIdx = r.bitIdx + 3'h1;
                     next_r.shift = {r.shift[6:0], 1'b0};
                     next_r.serial_in = r.shift[6];
                  end
               end
            end
         end
         H_END: begin
            // half a period of chip select hold after the last edge
            if (r.div != '0) begin
               next_r.div = r.div - 4'h1;
            end else begin
               next_r.csN = 1'b1;
               next_r.spi = H_IDLE;
            end
         end
         default: begin
            next_r.spi = H_IDLE;
            next_r.csN = 1'b1;
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= HOST_RESET;
      end else begin
         r <= next_r;
      end
   end

endmodule

/* File: verif/display_host_interface_chk.sv */
// wire-level assertions between the host end and the device end
`timescale 1ns/10ps
module display_host_interface_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic dcSel,
   input wire logic rwSel,
   input wire logic enRd,
   input wire logic [7:0] hostBusOe,
   input wire logic [7:0] busLevel
);
   logic prevClk;
   logic [3:0] rises;

   // ****************************************
   // serial clock rises within one frame
   // ****************************************
   always_ff @(posedge sys_clk) begin
      prevClk <= busLevel[0];
      if (rst || csN) begin
         rises <= 4'h0;
      end else if (busLevel[0] && !prevClk) begin
         rises <= rises + 4'h1;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   strobes_tied_a: assert property (!rwSel && !enRd)
      else $error("parallel strobe not low");
   d2_open_a: assert property (hostBusOe == 8'hfb)
      else $error("host bus enables wrong");
   unused_low_a: assert property (busLevel[7:3] == 5'h0)
      else $error("unused bus bits not low");
   idle_clock_a: assert property (csN |-> !busLevel[0])
      else $error("clock moves while deselected");
   select_setup_a: assert property ($fell(csN) |-> !busLevel[0] [*7])
      else $error("clock too soon after select");
   clock_high_a: assert property ($rose(busLevel[0]) |->
      busLevel[0] [*7] ##1 !busLevel[0])
      else $error("clock high time wrong");
   data_hold_a: assert property (busLevel[0] && $past(busLevel[0])
      |-> $stable(busLevel[1]))
      else $error("data moved while clock high");
   dc_stable_a: assert property (!csN && !$past(csN) |-> $stable(dcSel))
      else $error("data/command moved in frame");
   eight_bits_a: assert property ($rose(csN) |-> $past(rises) == 4'h8)
      else $error("frame bit count wrong");
endmodule

/* File: verif/display_host_interface_bench.sv */
// self-checking bench: host end and device end joined in serial mode
`timescale 1ns/10ps
`define CHK(g, e) check(32'(g), 32'(e))
module display_host_interface_bench;
   import display_link_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] paddr = 12'h0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic logicSupplyEn;
   logic panelSupplyEn;
   logic [7:0] readByte = 8'h0;
   logic [7:0] rxData;
   logic rxDc;
   logic rxValid;
   logic initActive;
   int fail_count = 0;
   int checks_done = 0;
   logic [8:0] expQ[$];
   logic [8:0] wireQ[$];
   logic prevClk = 1'b0;
   logic prevCs = 1'b1;
   logic [7:0] wireByte;
   logic wireDc;
   logic [31:0] rd;
   logic err;
   logic [8:0] w;

   display_link_if link();
   display_host_end #(.SETTLE_CYCLES(50)) display_host_end_i(
      .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link),
      .logicSupplyEn(logicSupplyEn), .panelSupplyEn(panelSupplyEn));
   display_device_end display_device_end_i(
      .sys_clk(sys_clk), .rst(rst), .link(link), .busSelLo(1'b0),
      .busSelHi(1'b0), .readByte(readByte), .rxData(rxData),
      .rxDc(rxDc), .rxValid(rxValid), .initActive(initActive));
   display_host_interface_chk display_host_interface_chk_i(
      .sys_clk(sys_clk), .rst(rst), .csN(link.csN), .dcSel(link.dcSel),
      .rwSel(link.rwSel), .enRd(link.enRd), .hostBusOe(link.hostBusOe),
      .busLevel(link.busLevel));

   always #10 sys_clk = ~sys_clk;

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task automatic finish_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // full fifo stalls a data write for a whole frame, hence the long bound
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      readByte <= 8'($urandom);
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 3000);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fail_count++;
         finish_test();
      end
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd & m, e);
   endtask

   // reset pin passes two sync flops before the device sees it
   task automatic ctrl(input logic [31:0] v);
      apb(1'b1, REG_CTRL, v);
      repeat (6) @(posedge sys_clk);
   endtask

   // ****************************************
   // wire sniffer and receive model
   // ****************************************
   always @(posedge sys_clk) begin
      prevClk <= link.busLevel[0];
      prevCs <= link.csN;
      if (!link.csN && link.busLevel[0] && !prevClk) begin
         wireByte <= {wireByte[6:0], link.busLevel[1]};
         wireDc <= link.dcSel;
      end
      if (link.csN && !prevCs && wireQ.size() > 0) begin
         `CHK({wireDc, wireByte}, wireQ.pop_front());
      end
      if (rxValid === 1'b1) begin
         // a byte nobody sent is a mismatch too
         `CHK(expQ.size() > 0, 1'b1);
         if (expQ.size() > 0) begin
            `CHK({rxDc, rxData}, expQ.pop_front());
         end
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h83171bfb));
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rdchk(REG_CTRL, 32'hffffffff, 32'h1);
      rdchk(REG_STATUS, 32'hb, 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      `CHK(err, 1'b1);
      `CHK(initActive, 1'b1);
      `CHK(link.hwResetN, 1'b0);
      ctrl(32'h4);
      `CHK(panelSupplyEn, 1'b0);
      ctrl(32'h2);
      `CHK(logicSupplyEn, 1'b1);
      `CHK(initActive, 1'b0);
      `CHK(link.hwResetN, 1'b1);
      for (int i = 0; i < 10; i++) begin
         w = (i < 2) ? {i[0], 8'ha5} : 9'($urandom);
         expQ.push_back(w);
         wireQ.push_back(w);
         apb(1'b1, REG_TXDATA, 32'(w));
         if (i == 4) begin
            rdchk(REG_STATUS, 32'h9, 32'h8);
         end
      end
      for (int n = 0; n < 5000 && expQ.size() + wireQ.size() > 0; n++) begin
         @(posedge sys_clk);
      end
      repeat (20) @(posedge sys_clk);
      `CHK(expQ.size() + wireQ.size(), 0);
      rdchk(REG_STATUS, 32'h3, 32'h1);
      ctrl(32'h6);
      `CHK(panelSupplyEn, 1'b1);
      ctrl(32'h0);
      `CHK(panelSupplyEn, 1'b0);
      `CHK(logicSupplyEn, 1'b1);
      rdchk(REG_STATUS, 32'h4, 32'h0);
      repeat (60) @(posedge sys_clk);
      rdchk(REG_STATUS, 32'h4, 32'h4);
      ctrl(32'h0);
      `CHK(logicSupplyEn, 1'b0);
      ctrl(32'h1);
      `CHK(initActive, 1'b1);
      finish_test();
   end
endmodule
